//--- src/pgr_pkg.sv
// Purpose: shared constants and types for the pager status/clock bank
// Assumes: 250 MHz system clock, 76.8 kHz decoder clock derived from it
// Notes: index values use only the low nibble of the index byte
package pgr_pkg;

   // clock rates and derived decoder clock divider
   localparam int CLOCK_HZ = 250000000;
   localparam int DEC_CLK_HZ = 76800;
   localparam int DEC_DIV = CLOCK_HZ / DEC_CLK_HZ;
   // one hundredth of a second in decoder clocks
   localparam int HUND_MS_X100 = 1;
   localparam int HUND_DEC_TICKS = DEC_CLK_HZ * HUND_MS_X100 / 100;
   // counter run-on after a zero modulus, in hundredths
   localparam int HALT_TIME_MS = 2550;
   localparam logic [7:0] HALT_HUNDREDTHS = 8'(HALT_TIME_MS / 10);

   // register indices
   localparam logic [3:0] IDX_STATUS = 4'h0;
   localparam logic [3:0] IDX_SECONDS = 4'h1;
   localparam logic [3:0] IDX_HUNDREDTHS = 4'h2;
   localparam logic [3:0] IDX_PERIODIC = 4'h5;

   // status bit positions
   localparam int ST_ALERT = 4;
   localparam int ST_RANGE = 5;
   localparam int ST_MON = 6;
   localparam int ST_PERIODIC = 7;
   // control bit positions
   localparam int CT_TERM = 0;
   localparam int CT_NVM = 1;
   localparam int CT_MON_SEL = 2;
   localparam int CT_RX_CONT = 3;
   localparam int CT_ON = 4;
   localparam int CT_MASK_RANGE = 5;
   localparam int CT_MASK_MON = 6;
   localparam int CT_MASK_PER = 7;

   // field values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] CALL_NONE = 2'h0;
   localparam logic [1:0] BUF_EMPTY = 2'h0;
   localparam logic [1:0] BUF_EQUAL = 2'h2;

   // clock limits and reference generator
   localparam logic [5:0] SEC_MAX = 6'h3b;
   localparam logic [6:0] HUND_MAX = 7'h63;
   localparam logic [6:0] HUND_HALF = 7'h31;
   localparam logic [6:0] REF_PULSES = 7'h20;
   localparam logic [6:0] REF_SPAN = 7'h4b;

   // reference rate selection
   typedef enum logic [1:0] {
      REF_32K, REF_50HZ, REF_2HZ, REF_MINUTE
   } pgr_ref_sel_type;

   // request kinds crossing from the link domain
   typedef enum logic [1:0] {
      REQ_WRITE, REQ_READ, REQ_DONE
   } pgr_req_kind_type;

   typedef struct packed {
      pgr_req_kind_type kind;
      logic [3:0] idx;
      logic [7:0] data;
   } pgr_req_type;

endpackage

//--- src/pgr_rtc.sv
// Purpose: decoder clock, real-time clock and reference pulse output
// Assumes: writes arrive as one-cycle strobes on the system clock
// Notes: reference pulses last one decoder clock except the square wave
`timescale 1ns/1ps
`default_nettype none
module pgr_rtc #(
   parameter int DIV = pgr_pkg::DEC_DIV,
   parameter int HUND_TICKS = pgr_pkg::HUND_DEC_TICKS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sec_wr_i,
   input wire logic hund_wr_i,
   input wire logic [7:0] wdata_i,
   input wire pgr_pkg::pgr_ref_sel_type ref_sel_i,
   input wire logic rx_on_i,
   output logic dec_tick_o,
   output logic hund_tick_o,
   output logic [5:0] seconds_o,
   output logic [6:0] hundredths_o,
   output logic ref_o
);
   import pgr_pkg::*;
   logic [15:0] div_cnt;
   logic [15:0] hund_pre;
   logic [6:0] acc;
   logic square;
   logic ref_pulse;

   // decoder clock and hundredth ticks
   assign dec_tick_o = (div_cnt == 16'(DIV - 1));
   assign hund_tick_o = dec_tick_o && (hund_pre == 16'(HUND_TICKS - 1));

   // 32 pulses spread over 75 decoder clocks
   wire [6:0] acc_sum = acc + REF_PULSES;
   wire acc_wrap = (acc_sum >= REF_SPAN);
   wire sec_wrap = (hundredths_o >= HUND_MAX);
   wire half_mark = (hundredths_o == HUND_HALF) || sec_wrap;
   wire minute_mark = sec_wrap && (seconds_o >= SEC_MAX);

   // reference pulse request per selected rate
   assign ref_pulse = (ref_sel_i == REF_32K) ? acc_wrap :
      (ref_sel_i == REF_2HZ) ? (hund_tick_o && half_mark) :
      (ref_sel_i == REF_MINUTE) ? (hund_tick_o && minute_mark && !rx_on_i) :
      1'b0;

   // prescalers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt <= '0;
         hund_pre <= '0;
         acc <= '0;
      end else begin
         div_cnt <= dec_tick_o ? '0 : div_cnt + 16'h0001;
         if (dec_tick_o) begin
            hund_pre <= hund_tick_o ? '0 : hund_pre + 16'h0001;
            acc <= acc_wrap ? acc_sum - REF_SPAN : acc_sum;
         end
      end
   end

   // seconds and hundredths, always counting
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         seconds_o <= '0;
         hundredths_o <= '0;
      end else begin
         if (hund_wr_i) begin
            hundredths_o <= wdata_i[6:0];
         end else if (hund_tick_o) begin
            hundredths_o <= sec_wrap ? '0 : hundredths_o + 7'h01;
         end
         if (sec_wr_i) begin
            seconds_o <= wdata_i[5:0];
         end else if (hund_tick_o && sec_wrap) begin
            seconds_o <= (seconds_o >= SEC_MAX) ? '0 : seconds_o + 6'h01;
         end
      end
   end

   // output stage, held for one decoder clock except the 50 Hz square wave
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         square <= 1'b0;
         ref_o <= 1'b0;
      end else begin
         if (hund_tick_o) begin
            square <= !square;
         end
         if (ref_sel_i == REF_50HZ) begin
            ref_o <= square;
         end else if (dec_tick_o) begin
            ref_o <= ref_pulse;
         end
      end
   end
endmodule
`default_nettype wire

//--- src/pgr_status_bank.sv
// Purpose: status, control, pending status, clock and periodic registers
// Assumes: index/byte requests come from the serial engine on LINK_CLK_I
// Notes: one request in flight at a time; LINK_BUSY_O holds off the next
`timescale 1ns/1ps
`default_nettype none
module pgr_status_bank #(
   parameter int DIV = pgr_pkg::DEC_DIV,
   parameter int HUND_TICKS = pgr_pkg::HUND_DEC_TICKS
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic LINK_CLK_I,
   input wire logic LINK_WR_I,
   input wire logic LINK_RD_I,
   input wire logic LINK_RD_DONE_I,
   input wire logic [7:0] LINK_IDX_I,
   input wire logic [7:0] LINK_WDATA_I,
   output logic LINK_BUSY_O,
   output logic LINK_RVALID_O,
   output logic [7:0] LINK_RDATA_O,
   input wire logic CALL_EVT_I,
   input wire logic [1:0] CALL_KIND_I,
   input wire logic [1:0] BUF_STATE_I,
   input wire logic ALERT_TIMEOUT_I,
   input wire logic RANGE_LOST_I,
   input wire logic RANGE_FOUND_I,
   input wire logic RX_REQ_I,
   input wire logic OSC_REQ_I,
   input wire logic TERM_DONE_I,
   input wire logic SUPPLY_LOW_IN_I,
   input wire logic DECODER_ON_IN_I,
   input wire logic [1:0] FACTORY_OPTION_BITS_I,
   output logic RECEIVER_ENABLE_OUT_O,
   output logic OSCILLATOR_ENABLE_OUT_O,
   output logic DECODER_ACTIVE_O,
   output logic FORCE_TERM_O,
   output logic NVM_PROG_EN_O,
   output logic INT_O,
   output logic REF_O
);
   import pgr_pkg::*;

   // ---------------- link domain ----------------
   pgr_req_type link_req;
   logic req_tgl, ack_s1, ack_s2, ack_seen, rd_wait, ack_tgl;
   logic [7:0] rd_word;

   // request capture only while no request is in flight
   wire link_any = LINK_WR_I || LINK_RD_I || LINK_RD_DONE_I;
   wire link_take = link_any && !LINK_BUSY_O;
   wire ack_edge = (ack_s2 != ack_seen);
   assign LINK_BUSY_O = (req_tgl != ack_s2);
   wire pgr_req_kind_type link_kind = LINK_WR_I ? REQ_WRITE :
      (LINK_RD_I ? REQ_READ : REQ_DONE);

   // request hold register and toggle
   always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         link_req <= '0;
         req_tgl <= 1'b0;
         rd_wait <= 1'b0;
      end else if (link_take) begin
         link_req.kind <= link_kind;
         link_req.idx <= LINK_IDX_I[3:0];
         link_req.data <= LINK_WDATA_I;
         req_tgl <= !req_tgl;
         rd_wait <= LINK_RD_I && !LINK_WR_I;
      end
   end

   // acknowledge sync and read data return
   always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         {ack_s1, ack_s2, ack_seen, LINK_RVALID_O} <= 4'h0;
         LINK_RDATA_O <= '0;
      end else begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
         ack_seen <= ack_s2;
         LINK_RVALID_O <= ack_edge && rd_wait;
         if (ack_edge && rd_wait) begin
            LINK_RDATA_O <= rd_word;
         end
      end
   end

   // ---------------- system domain ----------------
   logic req_s1, req_s2, req_s3, sup_s1, sup_s2, don_s1, don_s2;
   logic [1:0] opt_s1, opt_s2;

   // two-flop synchronisers for the toggle and the pins
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         {req_s1, req_s2, req_s3, sup_s1, sup_s2, don_s1, don_s2} <= 7'h00;
         {opt_s1, opt_s2} <= 4'h0;
      end else begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
         sup_s1 <= SUPPLY_LOW_IN_I;
         sup_s2 <= sup_s1;
         don_s1 <= DECODER_ON_IN_I;
         don_s2 <= don_s1;
         opt_s1 <= FACTORY_OPTION_BITS_I;
         opt_s2 <= opt_s1;
      end
   end

   // request decode; the hold register is stable while the toggle differs
   wire req_fire = (req_s2 != req_s3);
   wire wr_fire = req_fire && (link_req.kind == REQ_WRITE);
   wire rd_fire = req_fire && (link_req.kind == REQ_READ);
   wire done_fire = req_fire && (link_req.kind == REQ_DONE);
   wire wr_ctrl = wr_fire && (link_req.idx == IDX_STATUS);
   wire wr_sec = wr_fire && (link_req.idx == IDX_SECONDS);
   wire wr_hund = wr_fire && (link_req.idx == IDX_HUNDREDTHS);
   wire wr_mod = wr_fire && (link_req.idx == IDX_PERIODIC);

   logic [7:0] ctrl, stat, sec, modulus, count, halt_left;
   logic read_busy, pend_live, reassert, int_q, range_flag, range_bit;
   logic mon_bit, rx_prev, dec_tick, hund_tick;
   logic [1:0] buf_prev;
   logic [5:0] seconds;
   logic [6:0] hundredths;

   // clock and reference generator
   pgr_rtc #(
      .DIV(DIV),
      .HUND_TICKS(HUND_TICKS)
   ) u_rtc (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .sec_wr_i(wr_sec),
      .hund_wr_i(wr_hund),
      .wdata_i(link_req.data),
      .ref_sel_i(pgr_ref_sel_type'(opt_s2)),
      .rx_on_i(RECEIVER_ENABLE_OUT_O),
      .dec_tick_o(dec_tick),
      .hund_tick_o(hund_tick),
      .seconds_o(seconds),
      .hundredths_o(hundredths),
      .ref_o(REF_O)
   );

   // control outputs
   assign RECEIVER_ENABLE_OUT_O = ctrl[CT_RX_CONT] || RX_REQ_I;
   assign OSCILLATOR_ENABLE_OUT_O = ctrl[CT_RX_CONT] || OSC_REQ_I;
   assign DECODER_ACTIVE_O = ctrl[CT_ON] || don_s2;
   assign FORCE_TERM_O = ctrl[CT_TERM];
   assign NVM_PROG_EN_O = ctrl[CT_NVM];
   assign INT_O = int_q;

   // monitor source and live indicator changes
   wire mon_src = ctrl[CT_MON_SEL] ? RECEIVER_ENABLE_OUT_O : sup_s2;
   wire rx_fall = rx_prev && !RECEIVER_ENABLE_OUT_O;
   wire range_chg = rx_fall && (range_flag != range_bit);
   wire mon_chg = (mon_src != mon_bit);
   wire live_int = (range_chg && !ctrl[CT_MASK_RANGE]) ||
      (mon_chg && !ctrl[CT_MASK_MON]);

   // periodic counter step
   wire [7:0] count_inc = count + 8'h01;
   wire per_run = (modulus != 8'h00) || (halt_left != 8'h00);
   wire per_hit = hund_tick && (modulus != 8'h00) && (count_inc == modulus);
   wire buf_chg = (BUF_STATE_I != buf_prev);
   wire into_sec = read_busy;

   // status, pending register and interrupt next state
   logic [7:0] next_stat, next_sec;
   logic next_int, next_reassert, next_pend_live, evt_int;
   always_comb begin
      next_stat = stat;
      next_sec = sec;
      next_int = int_q;
      next_reassert = reassert;
      next_pend_live = pend_live;
      evt_int = 1'b0;
      if (done_fire && read_busy) begin
         next_stat[1:0] = sec[1:0];
         next_stat[2] = sec[2] || (stat[2] && (BUF_STATE_I != BUF_EQUAL));
         next_stat[3] = sec[3];
         next_stat[ST_ALERT] = sec[ST_ALERT];
         next_stat[ST_PERIODIC] = sec[ST_PERIODIC];
         next_sec = '0;
         next_int = 1'b0;
      end
      if (CALL_EVT_I) begin
         if (into_sec || (stat[1:0] != CALL_NONE)) begin
            next_sec[1:0] = CALL_KIND_I;
         end else begin
            next_stat[1:0] = CALL_KIND_I;
         end
         evt_int = 1'b1;
      end
      if (buf_chg) begin
         if (into_sec) begin
            next_sec[3:2] = BUF_STATE_I;
         end else begin
            next_stat[3:2] = BUF_STATE_I;
         end
         evt_int = evt_int || (BUF_STATE_I != BUF_EMPTY);
      end
      if (ALERT_TIMEOUT_I) begin
         if (into_sec) begin
            next_sec[ST_ALERT] = 1'b1;
         end else begin
            next_stat[ST_ALERT] = 1'b1;
         end
         evt_int = 1'b1;
      end
      if (per_hit) begin
         if (into_sec) begin
            next_sec[ST_PERIODIC] = 1'b1;
         end else begin
            next_stat[ST_PERIODIC] = 1'b1;
         end
         evt_int = evt_int || !ctrl[CT_MASK_PER];
      end
      if (live_int && into_sec) begin
         next_pend_live = 1'b1;
      end
      if (evt_int || live_int) begin
         if (into_sec) begin
            next_pend_live = next_pend_live || evt_int;
         end else begin
            next_int = 1'b1;
         end
      end
      if (done_fire && read_busy) begin
         next_reassert = ((sec | next_sec) != 8'h00) || next_pend_live;
      end else if (reassert && dec_tick) begin
         next_int = 1'b1;
         next_reassert = 1'b0;
      end
   end

   // status state registers
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         stat <= '0;
         sec <= '0;
         int_q <= 1'b0;
         reassert <= 1'b0;
         pend_live <= 1'b0;
         read_busy <= 1'b0;
         buf_prev <= BUF_EMPTY;
      end else begin
         stat <= next_stat;
         sec <= next_sec;
         int_q <= next_int;
         reassert <= next_reassert;
         pend_live <= next_pend_live && !(done_fire && read_busy);
         buf_prev <= BUF_STATE_I;
         if (rd_fire && (link_req.idx == IDX_STATUS)) begin
            read_busy <= 1'b1;
         end else if (done_fire) begin
            read_busy <= 1'b0;
         end
      end
   end

   // live indicators, never cleared by a read
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         range_flag <= 1'b0;
         range_bit <= 1'b0;
         mon_bit <= 1'b0;
         rx_prev <= 1'b0;
      end else begin
         if (RANGE_FOUND_I) begin
            range_flag <= 1'b0;
         end else if (RANGE_LOST_I) begin
            range_flag <= 1'b1;
         end
         if (rx_fall) begin
            range_bit <= range_flag;
         end
         mon_bit <= mon_src;
         rx_prev <= RECEIVER_ENABLE_OUT_O;
      end
   end

   // control register; termination done clears bit 0 unless rewritten
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= link_req.data;
      end else if (TERM_DONE_I) begin
         ctrl[CT_TERM] <= 1'b0;
      end
   end

   // periodic modulus and counter
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         modulus <= '0;
         count <= '0;
         halt_left <= '0;
      end else if (CALL_EVT_I) begin
         modulus <= '0;
         count <= '0;
         halt_left <= HALT_HUNDREDTHS;
      end else begin
         if (wr_mod) begin
            modulus <= link_req.data;
         end
         if (wr_mod && (link_req.data == 8'h00)) begin
            halt_left <= HALT_HUNDREDTHS;
         end else if (hund_tick && (modulus == 8'h00) && per_run) begin
            halt_left <= halt_left - 8'h01;
         end
         if (hund_tick && per_run) begin
            count <= per_hit ? 8'h00 : count_inc;
         end
      end
   end

   // read word, captured when the request is served
   wire [7:0] stat_view = {stat[ST_PERIODIC], mon_bit, range_bit,
      stat[ST_ALERT:0]};
   wire [7:0] rd_sel = (link_req.idx == IDX_STATUS) ? stat_view :
      (link_req.idx == IDX_SECONDS) ? {2'b00, seconds} :
      (link_req.idx == IDX_HUNDREDTHS) ? {1'b0, hundredths} :
      (link_req.idx == IDX_PERIODIC) ? count : 8'h00;

   // acknowledge toggle back to the link domain
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         rd_word <= '0;
         ack_tgl <= 1'b0;
      end else if (req_fire) begin
         ack_tgl <= !ack_tgl;
         if (rd_fire) begin
            rd_word <= rd_sel;
         end
      end
   end
endmodule
`default_nettype wire

//--- bench/pgr_status_bank_assertions.sv
// Purpose: port checks for the status bank
// Assumes: parameters match the bound instance
// Notes: system and link domains checked apart
`timescale 1ns/1ps
`default_nettype none
module pgr_status_bank_checker #(
   parameter int DIV = 4,
   parameter int HUND_TICKS = 4
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic LINK_CLK_I,
   input wire logic LINK_RD_I,
   input wire logic LINK_BUSY_O,
   input wire logic LINK_RVALID_O,
   input wire logic RX_REQ_I,
   input wire logic OSC_REQ_I,
   input wire logic TERM_DONE_I,
   input wire logic DECODER_ON_IN_I,
   input wire logic [1:0] FACTORY_OPTION_BITS_I,
   input wire logic RECEIVER_ENABLE_OUT_O,
   input wire logic OSCILLATOR_ENABLE_OUT_O,
   input wire logic DECODER_ACTIVE_O,
   input wire logic FORCE_TERM_O,
   input wire logic NVM_PROG_EN_O,
   input wire logic REF_O
);
   logic [15:0] run;
   // cycles the reference output has stayed high
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I)
         run <= 16'h0;
      else
         run <= REF_O ? run + 16'h1 : 16'h0;
   end
   chk_ref_width: assert property (@(posedge CLOCK_I)
      disable iff (RST_I) $fell(REF_O) |-> run == 16'(
      FACTORY_OPTION_BITS_I == 2'h1 ? DIV * HUND_TICKS : DIV))
      else $error("reference pulse width wrong");
   chk_rx_on: assert property (@(posedge CLOCK_I)
      disable iff (RST_I) RX_REQ_I |-> RECEIVER_ENABLE_OUT_O)
      else $error("receiver enable low");
   chk_osc_on: assert property (@(posedge CLOCK_I)
      disable iff (RST_I) OSC_REQ_I |-> OSCILLATOR_ENABLE_OUT_O)
      else $error("oscillator enable low");
   chk_decoder_on: assert property (@(posedge CLOCK_I)
      disable iff (RST_I) DECODER_ON_IN_I [*4] |-> DECODER_ACTIVE_O)
      else $error("decoder not on");
   chk_term_clear: assert property (@(posedge CLOCK_I)
      disable iff (RST_I) TERM_DONE_I && FORCE_TERM_O && !LINK_BUSY_O
      |=> !FORCE_TERM_O) else $error("termination bit stuck");
   chk_reset_ctrl: assert property (@(posedge CLOCK_I)
      disable iff (RST_I) $fell(RST_I) |-> !FORCE_TERM_O && !NVM_PROG_EN_O)
      else $error("control not cleared");
   chk_busy_take: assert property (@(posedge LINK_CLK_I)
      disable iff (RST_I) LINK_RD_I && !LINK_BUSY_O |=> LINK_BUSY_O)
      else $error("read not taken");
   chk_rvalid_once: assert property (@(posedge LINK_CLK_I)
      disable iff (RST_I) LINK_RVALID_O |=> !LINK_RVALID_O)
      else $error("read valid too long");
   // main scenarios reached
   cover property (@(posedge CLOCK_I) $fell(REF_O));
   cover property (@(posedge CLOCK_I) $fell(FORCE_TERM_O));
   cover property (@(posedge LINK_CLK_I) LINK_RVALID_O);
endmodule
bind pgr_status_bank pgr_status_bank_checker #(.DIV(DIV),
   .HUND_TICKS(HUND_TICKS)) u_chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
   .LINK_CLK_I(LINK_CLK_I), .LINK_RD_I(LINK_RD_I),
   .LINK_BUSY_O(LINK_BUSY_O), .LINK_RVALID_O(LINK_RVALID_O),
   .RX_REQ_I(RX_REQ_I), .OSC_REQ_I(OSC_REQ_I), .TERM_DONE_I(TERM_DONE_I),
   .DECODER_ON_IN_I(DECODER_ON_IN_I),
   .FACTORY_OPTION_BITS_I(FACTORY_OPTION_BITS_I),
   .RECEIVER_ENABLE_OUT_O(RECEIVER_ENABLE_OUT_O),
   .OSCILLATOR_ENABLE_OUT_O(OSCILLATOR_ENABLE_OUT_O),
   .DECODER_ACTIVE_O(DECODER_ACTIVE_O), .FORCE_TERM_O(FORCE_TERM_O),
   .NVM_PROG_EN_O(NVM_PROG_EN_O), .REF_O(REF_O));
`default_nettype wire

//--- bench/pgr_host_model.sv
// Purpose: link master model, one request at a time
// Assumes: a request is taken on a rising edge while busy is low
// Notes: idle index and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module pgr_host_model (
   input wire logic link_clk_i,
   input wire logic busy_i,
   output logic [2:0] req_o,
   output logic [7:0] idx_o,
   output logic [7:0] wdata_o
);
   // quiet lines at time zero
   initial begin
      req_o = 3'h0;
      idx_o = 8'h00;
      wdata_o = 8'h00;
   end
   // raise at a falling edge, hold over one taking edge, await idle
   task automatic req(input logic [2:0] k, input logic [7:0] i, d);
      int n;
      n = 0;
      @(negedge link_clk_i);
      while (busy_i !== 1'b0 && n < 64) begin
         @(negedge link_clk_i);
         n++;
      end
      req_o = k;
      idx_o = i;
      wdata_o = d;
      @(negedge link_clk_i);
      req_o = 3'h0;
      idx_o = ~i;
      wdata_o = ~d;
      while (busy_i !== 1'b0 && n < 128) begin
         @(negedge link_clk_i);
         n++;
      end
   endtask
endmodule
`default_nettype wire

//--- bench/tb_pager_status_rtc_periodic_regs.sv
// Purpose: self-checking bench for the pager status bank
// Assumes: short divider values keep the run brief
// Notes: link reads are checked against a queue of expected bytes
`timescale 1ns/1ps
`default_nettype none
module tb_pager_status_rtc_periodic_regs;
   import pgr_pkg::*;
   logic clk = 0, lclk = 0, rst = 1, busy, rv, call, alert, lost, found;
   logic rx, osc, term, slow, decoder_on_in, receiver_enable_out, oe, act, ft, nvm, intr, refo, rp;
   logic [1:0] kind, bufst, fac;
   logic [2:0] req;
   logic [7:0] idx, wd, rdata, r, exq[$];
   int error_cnt = 0, compares = 0, n, seed = 88;
   pgr_host_model u_host (.link_clk_i(lclk), .busy_i(busy), .req_o(req),
      .idx_o(idx), .wdata_o(wd));
   pgr_status_bank #(.DIV(4), .HUND_TICKS(4)) u_dut (.CLOCK_I(clk),
      .RST_I(rst), .LINK_CLK_I(lclk), .LINK_WR_I(req[2]),
      .LINK_RD_I(req[1]), .LINK_RD_DONE_I(req[0]), .LINK_IDX_I(idx),
      .LINK_WDATA_I(wd), .LINK_BUSY_O(busy), .LINK_RVALID_O(rv),
      .LINK_RDATA_O(rdata), .CALL_EVT_I(call), .CALL_KIND_I(kind),
      .BUF_STATE_I(bufst), .ALERT_TIMEOUT_I(alert), .RANGE_LOST_I(lost),
      .RANGE_FOUND_I(found), .RX_REQ_I(rx), .OSC_REQ_I(osc),
      .TERM_DONE_I(term), .SUPPLY_LOW_IN_I(slow), .DECODER_ON_IN_I(decoder_on_in),
      .FACTORY_OPTION_BITS_I(fac), .RECEIVER_ENABLE_OUT_O(receiver_enable_out),
      .OSCILLATOR_ENABLE_OUT_O(oe), .DECODER_ACTIVE_O(act),
      .FORCE_TERM_O(ft), .NVM_PROG_EN_O(nvm), .INT_O(intr), .REF_O(refo));
   // system clock and a link clock offset from it
   always #2 clk = ~clk;
   initial #0.7 forever #16 lclk = ~lclk;
   task automatic check(input logic [7:0] got, exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (error_cnt == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic tk(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic pul(ref logic s);
      tk(1);
      s = 1;
      tk(1);
      s = 0;
   endtask
   task automatic rd(input logic [7:0] i, e);
      exq.push_back(e);
      u_host.req(3'h2, i, 8'h00);
      tk(1);
   endtask
   task automatic wr(input logic [7:0] i, d);
      u_host.req(3'h4, i, d);
      tk(1);
   endtask
   task automatic sts(input logic [7:0] e);
      rd(8'h00, e);
      u_host.req(3'h1, 8'h00, 8'h00);
      tk(1);
   endtask
   // each answered read against the oldest note
   always @(negedge lclk) begin
      if (rv === 1'b1)
         check(rdata, exq.size() > 0 ? exq.pop_front() : ~rdata);
   end
   // hang guard
   initial begin
      #120000;
      error_cnt++;
      report_and_stop;
   end
   initial begin
      {call, alert, lost, found, rx, osc, term, slow, decoder_on_in, rp} = '0;
      {kind, bufst, fac} = '0;
      for (int m = 3; m >= 0; m--) begin
         fac = 2'(m);
         rst = 1;
         tk(20);
         rst = 0;
         n = 0;
         repeat (1200) begin
            tk(1);
            n += int'(refo === 1'b1 && !rp);
            rp = (refo === 1'b1);
         end
      end
      check(8'(n >= 127 && n <= 129), 8'h01);
      sts(8'h00);
      wr(8'h02, 8'h80);
      wr(8'h01, 8'hfb);
      rd(8'h01, 8'h3b);
      tk(1600);
      rd(8'h01, 8'h00);
      r = 8'($random(seed)) & 8'hdf;
      wr(8'h01, r);
      rd(8'h01, r & 8'h1f);
      wr(8'h0b, 8'hff);
      rd(8'h0b, 8'h00);
      wr(8'h15, 8'h05);
      for (n = 0; intr !== 1'b1 && n < 5000; n++) tk(1);
      check({7'h0, intr}, 8'h01);
      wr(8'h05, 8'h00);
      sts(8'h80);
      check({7'h0, intr}, 8'h00);
      sts(8'h00);
      for (int k = 1; k < 4; k++) begin
         kind = 2'(k);
         pul(call);
      end
      tk(4500);
      rd(8'h05, 8'hff);
      sts(8'h01);
      check({7'h0, intr}, 8'h01);
      sts(8'h03);
      rx = 1;
      pul(lost);
      rx = 0;
      tk(8);
      check({7'h0, intr}, 8'h01);
      sts(8'h20);
      sts(8'h20);
      wr(8'h00, 8'h20);
      rx = 1;
      pul(found);
      rx = 0;
      tk(8);
      check({7'h0, intr}, 8'h00);
      sts(8'h00);
      wr(8'h00, 8'h1b);
      check({3'h0, receiver_enable_out, oe, act, ft, nvm}, 8'h1f);
      pul(term);
      check({6'h0, ft, nvm}, 8'h01);
      wr(8'h00, 8'h0c);
      sts(8'h40);
      slow = 1;
      wr(8'h00, 8'h00);
      {decoder_on_in, osc} = 2'b11;
      sts(8'h40);
      {decoder_on_in, osc, slow} = 3'b000;
      pul(alert);
      bufst = 2'h1;
      sts(8'h14);
      sts(8'h04);
      tk(20);
      check(8'(exq.size()), 8'h00);
      report_and_stop;
   end
endmodule
`default_nettype wire
